// ==== include/spg_pkg.sv ====
// stack pointer / interrupt gate constants
// assumes a 4-bit core supplies pointer load and step strobes
package spg_pkg;
  localparam int SPG_WIDE_W = 10;
  localparam int SPG_NIB_W = 8;
  localparam int SPG_ADDR_W = 16;
  localparam logic [SPG_WIDE_W-1:0] SPG_WIDE_RST = 10'h000;
  localparam logic [SPG_WIDE_W-1:0] SPG_WIDE_MAX = 10'h3ff;
  localparam logic [SPG_NIB_W-1:0] SPG_NIB_RST = 8'h00;
  localparam logic [SPG_NIB_W-1:0] SPG_NIB_MAX = 8'hff;
  localparam logic [SPG_ADDR_W-1:0] SPG_WIDE_LO = 16'h0100;
  localparam logic [SPG_ADDR_W-1:0] SPG_WIDE_HI = 16'h01ff;
  typedef enum logic [1:0] {SPG_OP_NONE, SPG_OP_PUSH, SPG_OP_POP} spg_op_t;
  typedef enum logic [1:0] {SPG_GATE_CLOSED, SPG_GATE_WIDE, SPG_GATE_NIB, SPG_GATE_OPEN}
    spg_gate_t;
endpackage

// ==== src/spg_ptr.sv ====
// one cyclic stack pointer of parameterised width
// assumes load and step strobes are synchronous single-cycle pulses
`timescale 1ns/10ps
module spg_ptr #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_load,
  input wire logic [W-1:0] i_load_val,
  input wire spg_pkg::spg_op_t i_op,
  output logic [W-1:0] o_ptr
);
  import spg_pkg::*;
  logic [W-1:0] ptr_reg;
  logic [W-1:0] ptr_next;
  // push predecrements; natural width overflow gives the cyclic wrap
  always_comb begin
    ptr_next = ptr_reg;
    if (i_load) begin
      ptr_next = i_load_val;
    end else if (i_op == SPG_OP_PUSH) begin
      ptr_next = ptr_reg - W'(1);
    end else if (i_op == SPG_OP_POP) begin
      ptr_next = ptr_reg + W'(1);
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ptr_reg <= '0;
    end else begin
      ptr_reg <= ptr_next;
    end
  end
  assign o_ptr = ptr_reg;
endmodule

// ==== src/spg_gate.sv ====
// stack pointer pair with interrupt acceptance gate
// assumes the core issues at most one op per pointer per cycle
`timescale 1ns/10ps
// What this block does
// - wide pointer wraps within 0000h..03ffh
// - nibble pointer wraps within 0000h..00ffh
// - 16-bit stack transfers use wide pointer
// - 4-bit stack data uses nibble pointer
// - only wide stack accesses are 16-bit
// - 16-bit access only inside 0100h..01ffh
// - after reset interrupts blocked until both loaded
// - reloading one pointer blocks until other reloaded
module spg_gate (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wide_load,
  input wire logic [spg_pkg::SPG_WIDE_W-1:0] i_wide_val,
  input wire spg_pkg::spg_op_t i_wide_op,
  input wire logic i_nib_load,
  input wire logic [spg_pkg::SPG_NIB_W-1:0] i_nib_val,
  input wire spg_pkg::spg_op_t i_nib_op,
  input wire logic i_irq_req,
  input wire logic i_nmi_req,
  output logic [spg_pkg::SPG_WIDE_W-1:0] o_wide_stack_pointer,
  output logic [spg_pkg::SPG_NIB_W-1:0] o_nibble_stack_pointer,
  output logic [spg_pkg::SPG_ADDR_W-1:0] o_wide_addr,
  output logic o_wide_access_16,
  output logic o_wide_in_range,
  output logic [spg_pkg::SPG_ADDR_W-1:0] o_nib_addr,
  output logic o_int_enable,
  output logic o_irq_take,
  output logic o_nmi_take
);
  import spg_pkg::*;

  function automatic logic [SPG_ADDR_W-1:0] spg_ext(input logic [SPG_WIDE_W-1:0] v);
    spg_ext = {{(SPG_ADDR_W-SPG_WIDE_W){1'b0}}, v};
  endfunction

  // shared by the access logic and in_window_a so both see one window
  function automatic logic spg_in_window(input logic [SPG_ADDR_W-1:0] a);
    spg_in_window = (a >= SPG_WIDE_LO) && (a <= SPG_WIDE_HI);
  endfunction

  logic [SPG_WIDE_W-1:0] wide_ptr;
  logic [SPG_NIB_W-1:0] nib_ptr;
  logic wide_flag_reg, wide_flag_next, nib_flag_reg, nib_flag_next;
  logic en_reg, en_next;
  logic [SPG_WIDE_W-1:0] wide_addr_w;
  logic wide_addr_ok;

  spg_ptr #(.W(SPG_WIDE_W)) u_wide (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_load(i_wide_load),
    .i_load_val(i_wide_val),
    .i_op(i_wide_op),
    .o_ptr(wide_ptr)
  );
  spg_ptr #(.W(SPG_NIB_W)) u_nib (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_load(i_nib_load),
    .i_load_val(i_nib_val),
    .i_op(i_nib_op),
    .o_ptr(nib_ptr)
  );

  // pair-load tracking; a pair completes and flags clear
  always_comb begin
    wide_flag_next = wide_flag_reg | i_wide_load;
    nib_flag_next = nib_flag_reg | i_nib_load;
    en_next = en_reg;
    if (wide_flag_next && nib_flag_next) begin
      wide_flag_next = 1'b0;
      nib_flag_next = 1'b0;
      en_next = 1'b1;
    end else if (i_wide_load || i_nib_load) begin
      en_next = 1'b0;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wide_flag_reg <= 1'b0;
      nib_flag_reg <= 1'b0;
      en_reg <= 1'b0;
    end else begin
      wide_flag_reg <= wide_flag_next;
      nib_flag_reg <= nib_flag_next;
      en_reg <= en_next;
    end
  end

  // push uses the predecremented slot, pop the current one
  assign wide_addr_w = (i_wide_op == SPG_OP_PUSH) ? wide_ptr - 10'h001 : wide_ptr;
  assign wide_addr_ok = spg_in_window(spg_ext(wide_addr_w));

  assign o_wide_stack_pointer = wide_ptr;
  assign o_nibble_stack_pointer = nib_ptr;
  assign o_wide_addr = spg_ext(wide_addr_w);
  assign o_nib_addr = {{(SPG_ADDR_W-SPG_NIB_W){1'b0}}, nib_ptr};
  // 16-bit only for in-window wide stack ops
  assign o_wide_access_16 = (i_wide_op != SPG_OP_NONE) && wide_addr_ok;
  assign o_wide_in_range = wide_addr_ok;
  assign o_int_enable = en_reg;
  assign o_irq_take = en_reg & i_irq_req;
  assign o_nmi_take = en_reg & i_nmi_req;

  reset_closed_a: assert property (@(posedge i_clk) $rose(i_rst_n) |-> !o_int_enable)
    else $error("gate open right after reset");
  single_reload_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_int_enable && i_wide_load && !i_nib_load) |=> !o_int_enable)
    else $error("gate stayed open after single reload");
  nib_reload_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_int_enable && i_nib_load && !i_wide_load) |=> !o_int_enable)
    else $error("gate stayed open after nibble reload");
  reset_flags_a: assert property (@(posedge i_clk) $rose(i_rst_n) |->
    !wide_flag_reg && !nib_flag_reg)
    else $error("load flags set right after reset");

  sequence pair_seq;
    i_wide_load && i_nib_load;
  endsequence
  pair_open_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    pair_seq |=> o_int_enable && !wide_flag_reg && !nib_flag_reg)
    else $error("pair load did not open gate");
  sequence nib_reload_seq;
    o_int_enable && i_nib_load && !i_wide_load;
  endsequence
  sequence no_load_seq;
    !i_wide_load && !i_nib_load;
  endsequence
  sequence wide_only_seq;
    i_wide_load && !i_nib_load;
  endsequence
  reload_pair_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    nib_reload_seq ##1 no_load_seq ##1 wide_only_seq |=> o_int_enable)
    else $error("gate stayed shut after pair rewrite");
  half_pair_closed_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wide_flag_reg ^ nib_flag_reg) |-> !o_int_enable)
    else $error("gate open with half a pair loaded");
  flags_apart_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !(wide_flag_reg && nib_flag_reg))
    else $error("both load flags left set");

  nmi_block_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !o_int_enable |-> !o_nmi_take && !o_irq_take)
    else $error("interrupt taken while gated");
  gate_pass_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_int_enable |-> (o_irq_take == i_irq_req) && (o_nmi_take == i_nmi_req))
    else $error("request lost while gate open");

  wide_wrap_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wide_ptr == SPG_WIDE_MAX && i_wide_op == SPG_OP_POP && !i_wide_load)
    |=> wide_ptr == SPG_WIDE_RST)
    else $error("wide pointer wrap wrong");
  wide_wrap_low_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wide_ptr == SPG_WIDE_RST && i_wide_op == SPG_OP_PUSH && !i_wide_load)
    |=> wide_ptr == SPG_WIDE_MAX)
    else $error("wide pointer low wrap wrong");
  nib_wrap_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (nib_ptr == SPG_NIB_RST && i_nib_op == SPG_OP_PUSH && !i_nib_load)
    |=> nib_ptr == SPG_NIB_MAX)
    else $error("nibble pointer wrap wrong");
  nib_wrap_high_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (nib_ptr == SPG_NIB_MAX && i_nib_op == SPG_OP_POP && !i_nib_load)
    |=> nib_ptr == SPG_NIB_RST)
    else $error("nibble pointer high wrap wrong");

  window_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_wide_access_16 |-> o_wide_addr >= SPG_WIDE_LO && o_wide_addr <= SPG_WIDE_HI)
    else $error("16-bit access outside window");
  in_window_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_wide_op != SPG_OP_NONE && spg_in_window(o_wide_addr)) |-> o_wide_access_16)
    else $error("in-window wide op not 16-bit");
  narrow_idle_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_wide_op == SPG_OP_NONE) |-> !o_wide_access_16)
    else $error("16-bit access without stack op");

  push_addr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_wide_op == SPG_OP_PUSH) |-> o_wide_addr == spg_ext(wide_ptr - 10'h001))
    else $error("wide push address wrong");
  wide_step_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_wide_op == SPG_OP_PUSH && !i_wide_load) |=> wide_ptr == $past(wide_ptr) - 10'h001)
    else $error("wide push step wrong");
  wide_pop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_wide_op == SPG_OP_POP && !i_wide_load) |=> wide_ptr == $past(wide_ptr) + 10'h001)
    else $error("wide pop step wrong");
  wide_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_wide_load |=> wide_ptr == $past(i_wide_val))
    else $error("wide load value lost");
  nib_step_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_nib_op == SPG_OP_POP && !i_nib_load) |=> nib_ptr == $past(nib_ptr) + 8'h01)
    else $error("nibble pop step wrong");
  nib_push_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_nib_op == SPG_OP_PUSH && !i_nib_load) |=> nib_ptr == $past(nib_ptr) - 8'h01)
    else $error("nibble push step wrong");
  nib_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_nib_load |=> nib_ptr == $past(i_nib_val))
    else $error("nibble load value lost");

  gate_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!i_wide_load && !i_nib_load) |=> $stable(o_int_enable))
    else $error("gate changed without load");
endmodule

// ==== tb/spg_gate_bench.sv ====
// bench for the stack pointer pair and interrupt gate
// assumes spg_pkg is compiled first; the bench drives every port itself
`timescale 1ns/10ps
module spg_gate_bench;
  import spg_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_wide_load = 1'b0;
  logic i_nib_load = 1'b0;
  logic i_irq_req = 1'b0;
  logic i_nmi_req = 1'b0;
  logic [SPG_WIDE_W-1:0] i_wide_val = 10'h000;
  logic [SPG_NIB_W-1:0] i_nib_val = 8'h00;
  spg_op_t i_wide_op = SPG_OP_NONE;
  spg_op_t i_nib_op = SPG_OP_NONE;
  logic [SPG_WIDE_W-1:0] wp;
  logic [SPG_NIB_W-1:0] np;
  logic [SPG_ADDR_W-1:0] wa, na;
  logic a16, inr, ien, irq_t, nmi_t;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;
  spg_gate dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wide_load(i_wide_load),
    .i_wide_val(i_wide_val), .i_wide_op(i_wide_op), .i_nib_load(i_nib_load),
    .i_nib_val(i_nib_val), .i_nib_op(i_nib_op), .i_irq_req(i_irq_req),
    .i_nmi_req(i_nmi_req), .o_wide_stack_pointer(wp), .o_nibble_stack_pointer(np),
    .o_wide_addr(wa), .o_wide_access_16(a16), .o_wide_in_range(inr), .o_nib_addr(na),
    .o_int_enable(ien), .o_irq_take(irq_t), .o_nmi_take(nmi_t));
  always #10 i_clk = ~i_clk;
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard: the whole run needs well under 200 cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      final_report;
    end
  end
  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: flag %b want %b", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: value %h want %h", $time, got, exp);
    end
  endtask
  // one-cycle load pulse; checks land after the sampling edge settles
  task automatic load(input logic w, input logic [9:0] wv, input logic n, input logic [7:0] nv);
    @(posedge i_clk);
    {i_wide_load, i_wide_val, i_nib_load, i_nib_val} <= {w, wv, n, nv};
    @(posedge i_clk);
    {i_wide_load, i_nib_load} <= 2'b00;
    #1;
  endtask
  task automatic set_ops(input spg_op_t w, input spg_op_t n);
    @(posedge i_clk);
    i_wide_op <= w;
    i_nib_op <= n;
    #1;
  endtask
  task automatic t_gate;
    chk_bit(ien, 1'b0);
    chk_bit(nmi_t, 1'b0);
    load(1'b1, 10'h100, 1'b0, 8'h00);
    chk_bit(irq_t, 1'b0);
    load(1'b0, 10'h000, 1'b1, 8'h40);
    chk_bit(ien, 1'b1);
    chk_bit(nmi_t, 1'b1);
    load(1'b0, 10'h000, 1'b1, 8'h41);
    chk_bit(nmi_t, 1'b0);
    chk_bit(irq_t, 1'b0);
    load(1'b1, 10'h1f0, 1'b0, 8'h00);
    chk_bit(irq_t, 1'b1);
    $display("test gate done");
  endtask
  task automatic t_wrap;
    load(1'b1, 10'h3ff, 1'b1, 8'hff);
    set_ops(SPG_OP_POP, SPG_OP_POP);
    set_ops(SPG_OP_PUSH, SPG_OP_PUSH);
    chk_val({6'h00, wp}, 16'h0000);
    chk_val({8'h00, np}, 16'h0000);
    set_ops(SPG_OP_NONE, SPG_OP_NONE);
    chk_val({6'h00, wp}, 16'h03ff);
    chk_val({8'h00, np}, 16'h00ff);
    $display("test wrap done");
  endtask
  task automatic t_addr;
    load(1'b1, 10'h101, 1'b1, 8'h12);
    chk_bit(a16, 1'b0);
    set_ops(SPG_OP_PUSH, SPG_OP_NONE);
    chk_val(wa, 16'h0100);
    chk_bit(a16, 1'b1);
    chk_val(na, 16'h0012);
    load(1'b1, 10'h200, 1'b0, 8'h00);
    chk_val(wa, 16'h01ff);
    chk_bit(inr, 1'b1);
    set_ops(SPG_OP_POP, SPG_OP_NONE);
    chk_val(wa, 16'h01ff);
    set_ops(SPG_OP_POP, SPG_OP_NONE);
    chk_bit(a16, 1'b0);
    chk_bit(inr, 1'b0);
    set_ops(SPG_OP_NONE, SPG_OP_NONE);
    $display("test addr done");
  endtask
  // mid-run reset must drop a half-loaded pair and both pointers
  task automatic t_reset;
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    #1;
    chk_bit(ien, 1'b0);
    chk_bit(nmi_t, 1'b0);
    chk_val({6'h00, wp}, 16'h0000);
    chk_val({8'h00, np}, 16'h0000);
    load(1'b0, 10'h000, 1'b1, 8'h20);
    chk_bit(irq_t, 1'b0);
    load(1'b1, 10'h1c0, 1'b1, 8'h21);
    chk_bit(ien, 1'b1);
    $display("test reset done");
  endtask
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    {i_irq_req, i_nmi_req} <= 2'b11;
    #1;
    t_gate();
    t_wrap();
    t_addr();
    t_reset();
    final_report();
  end
endmodule
